/* psa_pkg.sv */
// Constants and types for the program store access controller
package psa_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_HZ          = 100_000_000;
    localparam int PWR_ON_DELAY_MS = 18;
    localparam int PWR_ON_CYC      = PWR_ON_DELAY_MS * (CLK_HZ / 1000);
    localparam int PROG_MAX_US     = 10000;
    localparam int PROG_MAX_CYC    = PROG_MAX_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W           = 21;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_ADDR_LOW  = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA_LOW  = 8'h08;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h0c;
    localparam logic [7:0] OFS_CONTROL   = 8'h10;
    localparam logic [7:0] OFS_UNLOCK    = 8'h14;
    localparam logic [7:0] OFS_FLAGS     = 8'h18;
    localparam logic [7:0] OFS_MASK      = 8'h1c;
    // ==========================================================
    // Fields
    localparam int CTL_RD      = 0;
    localparam int CTL_WR      = 1;
    localparam int CTL_ALLOW   = 2;
    localparam int CTL_ERR     = 3;
    localparam int CTL_TIME_LO = 4;
    localparam int CTL_TIME_HI = 5;
    localparam int CTL_SEL     = 7;
    localparam int FLG_DONE    = 0;
    localparam int FLG_ERR     = 1;
    localparam int ADDR_HIGH_W = 3;
    localparam logic [1:0] TIME_CODE_MAX = 2'h3;
    localparam logic [7:0] UNLOCK_KEY1   = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2   = 8'haa;
    // ==========================================================
    // Unlock steps and states
    localparam logic [1:0] UNL_IDLE  = 2'h0;
    localparam logic [1:0] UNL_KEY1  = 2'h1;
    localparam logic [1:0] UNL_ARMED = 2'h2;
    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0001,
        ST_RD_ACCESS = 4'b0010,
        ST_RD_LATCH  = 4'b0100,
        ST_PROG      = 4'b1000
    } psa_state_type;
endpackage

/* psa_program_store_access_ctrl.sv */
// Program store access controller with APB registers
`timescale 1ns/100ps
// Overview of operation
// - Read uses the second instruction period; that instruction is squashed.
// - Next period latches a program word into both data registers, or an EEPROM byte into the low one with the high one cleared; held until next access.
// - Write strobe with program memory selected clears at once, nothing happens.
// - Program memory array is never modified; only reads reach it.
// - EEPROM byte programming lasts 100us to 10ms, bounded by time field.
// - Programming ends on self-check success or maximum time, whichever first.
// - CPU halts during an EEPROM write; other peripherals keep running.
// - Write allow bit is cleared at power-up.
// - All EEPROM writes are blocked during the 18ms power-on delay.
// - Write starts only with unlock sequence done and write allow set.
// - Time field codes 00 to 11 select 1.25, 2.5, 5 or 10ms.
// - Unlock port takes 55h then AAh, then write strobe; else no write.
// - Error flag sets on reset-interrupted write or timeout before self-check.
// - Completion clears write strobe and sets software-cleared done flag.
module psa_program_store_access_ctrl
    import psa_pkg::*;
#(
    parameter int PWR_ON_CYC_P   = psa_pkg::PWR_ON_CYC,
    parameter int PROG_MAX_CYC_P = psa_pkg::PROG_MAX_CYC
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq,
    // CPU core
    output logic             cpu_stall,
    output logic             cpu_squash,
    input  wire logic        wdt_lvr_reset,
    // Program memory array
    output logic [10:0]      prog_addr,
    output logic             prog_rd,
    input  wire logic [15:0] prog_rdata,
    // EEPROM array
    output logic [7:0]       ee_addr,
    output logic [7:0]       ee_wdata,
    output logic             ee_rd,
    input  wire logic [7:0]  ee_rdata,
    output logic             ee_prog,
    input  wire logic        ee_verify_ok
);
    import psa_pkg::*;

    // ==========================================================
    // Storage
    logic [7:0]             addr_low_q;
    logic [ADDR_HIGH_W-1:0] addr_high_q;
    logic [7:0]             data_low_q;
    logic [7:0]             data_high_q;
    logic                   sel_q;
    logic [1:0]             time_q;
    logic                   err_q;
    logic                   allow_q;
    logic                   rd_q;
    logic                   wr_q;
    logic [1:0]             unlock_q;
    logic [1:0]             flag_q;
    logic [1:0]             mask_q;
    logic [CNT_W-1:0]       por_cnt_q;
    logic [CNT_W-1:0]       prog_cnt_q;
    psa_state_type          state_q;
    psa_state_type          state_d;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   irq_q;
    logic                   stall_q;
    logic                   squash_q;
    logic                   prog_rd_q;
    logic                   ee_rd_q;

    // ==========================================================
    // Bus decode
    wire setup_ph      = psel & ~penable;
    wire wr_acc        = psel & penable & pready_q & pwrite;
    wire hit_addr_low  = paddr == OFS_ADDR_LOW;
    wire hit_addr_high = paddr == OFS_ADDR_HIGH;
    wire hit_data_low  = paddr == OFS_DATA_LOW;
    wire hit_data_high = paddr == OFS_DATA_HIGH;
    wire hit_control   = paddr == OFS_CONTROL;
    wire hit_unlock    = paddr == OFS_UNLOCK;
    wire hit_flags     = paddr == OFS_FLAGS;
    wire hit_mask      = paddr == OFS_MASK;
    wire mapped        = hit_addr_low | hit_addr_high | hit_data_low | hit_data_high
                       | hit_control | hit_unlock | hit_flags | hit_mask;
    wire [7:0] ctl_rd_val = {sel_q, 1'b0, time_q, err_q, allow_q, wr_q, rd_q};
    wire [7:0] rd_mux =
        hit_addr_low  ? addr_low_q :
        hit_addr_high ? {{(8 - ADDR_HIGH_W){1'b0}}, addr_high_q} :
        hit_data_low  ? data_low_q :
        hit_data_high ? data_high_q :
        hit_control   ? ctl_rd_val :
        hit_flags     ? {6'h00, flag_q} :
        hit_mask      ? {6'h00, mask_q} : 8'h00;

    // ==========================================================
    // Requests
    wire ctl_wr      = wr_acc & hit_control;
    wire idle        = state_q == ST_IDLE;
    wire por_busy    = por_cnt_q != CNT_W'(PWR_ON_CYC_P);
    wire unlocked    = unlock_q == UNL_ARMED;
    // Program memory selected never starts a write
    wire wr_start    = ctl_wr & pwdata[CTL_WR] & ~pwdata[CTL_SEL]
                     & pwdata[CTL_ALLOW] & unlocked
                     & ~por_busy & idle;
    wire rd_start    = ctl_wr & pwdata[CTL_RD] & idle & ~wr_start;
    wire in_prog     = state_q == ST_PROG;
    // Longest time halves per code step below the top code
    wire [CNT_W-1:0] prog_limit =
        CNT_W'(PROG_MAX_CYC_P >> (TIME_CODE_MAX - time_q));
    wire abort_ev    = in_prog & wdt_lvr_reset;
    wire ok_ev       = in_prog & ~wdt_lvr_reset & ee_verify_ok;
    wire tmo_ev      = in_prog & ~wdt_lvr_reset & ~ee_verify_ok
                     & (prog_cnt_q == prog_limit - CNT_W'(1));
    wire prog_end    = abort_ev | ok_ev | tmo_ev;
    wire err_ev      = abort_ev | tmo_ev;
    wire done_ev     = ok_ev | tmo_ev;
    wire [1:0] flag_set = {err_ev, done_ev};
    wire [1:0] flag_clr = (wr_acc & hit_flags) ? pwdata[1:0] : 2'h0;
    wire [1:0] flag_d   = (flag_q & ~flag_clr) | flag_set;

    // ==========================================================
    // Sequencer
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (wr_start)
                    state_d = ST_PROG;
                else if (rd_start)
                    state_d = ST_RD_ACCESS;
            end
            ST_RD_ACCESS: state_d = ST_RD_LATCH;
            ST_RD_LATCH:  state_d = ST_IDLE;
            ST_PROG:
            begin
                if (prog_end)
                    state_d = ST_IDLE;
            end
            default:      state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // APB answer, one cycle after setup
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= setup_ph;
            pslverr_q <= setup_ph & ~mapped;
            prdata_q  <= (setup_ph & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Address, control and mask registers
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_low_q  <= 8'h00;
            addr_high_q <= '0;
            sel_q       <= 1'b0;
            time_q      <= 2'h0;
            allow_q     <= 1'b0;
            mask_q      <= 2'h0;
        end
        else
        begin
            if (wr_acc & hit_addr_low)
                addr_low_q <= pwdata[7:0];
            if (wr_acc & hit_addr_high)
                addr_high_q <= pwdata[ADDR_HIGH_W-1:0];
            if (wr_acc & hit_mask)
                mask_q <= pwdata[1:0];
            if (ctl_wr)
            begin
                sel_q   <= pwdata[CTL_SEL];
                time_q  <= pwdata[CTL_TIME_HI:CTL_TIME_LO];
                allow_q <= pwdata[CTL_ALLOW];
            end
        end
    end

    // ==========================================================
    // Strobes, error bit and flags; hardware set beats software write
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_q   <= 1'b0;
            wr_q   <= 1'b0;
            err_q  <= 1'b0;
            flag_q <= 2'h0;
            irq_q  <= 1'b0;
        end
        else
        begin
            rd_q   <= rd_start | (rd_q & ~(state_q == ST_RD_LATCH));
            wr_q   <= wr_start | (wr_q & ~prog_end);
            err_q  <= err_ev | (ctl_wr ? pwdata[CTL_ERR] : err_q);
            flag_q <= flag_d;
            irq_q  <= |(flag_d & mask_q);
        end
    end

    // ==========================================================
    // Unlock sequence; any other write breaks it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            unlock_q <= UNL_IDLE;
        else if (wr_acc)
        begin
            if (hit_unlock & (pwdata[7:0] == UNLOCK_KEY1))
                unlock_q <= UNL_KEY1;
            else if (hit_unlock & (pwdata[7:0] == UNLOCK_KEY2) & (unlock_q == UNL_KEY1))
                unlock_q <= UNL_ARMED;
            else
                unlock_q <= UNL_IDLE;
        end
    end

    // ==========================================================
    // Power-on delay and programming timer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_cnt_q  <= '0;
            prog_cnt_q <= '0;
        end
        else
        begin
            if (por_busy)
                por_cnt_q <= por_cnt_q + CNT_W'(1);
            prog_cnt_q <= in_prog ? prog_cnt_q + CNT_W'(1) : '0;
        end
    end

    // ==========================================================
    // Array strobes, stall and data latch
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_rd_q   <= 1'b0;
            ee_rd_q     <= 1'b0;
            squash_q    <= 1'b0;
            stall_q     <= 1'b0;
            data_low_q  <= 8'h00;
            data_high_q <= 8'h00;
        end
        else
        begin
            prog_rd_q <= rd_start & pwdata[CTL_SEL];
            ee_rd_q   <= rd_start & ~pwdata[CTL_SEL];
            squash_q  <= state_q == ST_RD_ACCESS;
            stall_q   <= state_d == ST_PROG;
            if (state_q == ST_RD_LATCH)
            begin
                data_low_q  <= sel_q ? prog_rdata[7:0] : ee_rdata;
                data_high_q <= sel_q ? prog_rdata[15:8] : 8'h00;
            end
            else
            begin
                if (wr_acc & hit_data_low)
                    data_low_q <= pwdata[7:0];
                if (wr_acc & hit_data_high)
                    data_high_q <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // Outputs
    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign irq        = irq_q;
    assign cpu_stall  = stall_q;
    assign cpu_squash = squash_q;
    assign prog_addr  = {addr_high_q, addr_low_q};
    assign prog_rd    = prog_rd_q;
    assign ee_addr    = addr_low_q;
    assign ee_wdata   = data_low_q;
    assign ee_rd      = ee_rd_q;
    assign ee_prog    = stall_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_read_squash: assert property (
        (prog_rd || ee_rd) |=> cpu_squash ##1 !cpu_squash)
        else $error("read did not squash one period");
    chk_word_latch: assert property (
        (cpu_squash && sel_q) |=> data_low_q == $past(prog_rdata[7:0])
            && data_high_q == $past(prog_rdata[15:8]))
        else $error("program word not latched");
    chk_data_hold: assert property (
        (idle && !(wr_acc && (hit_data_low || hit_data_high))) |=> $stable(data_low_q))
        else $error("data register changed without access");
    chk_pgm_write_void: assert property (
        (ctl_wr && pwdata[CTL_SEL] && !wr_q) |=> !wr_q && !ee_prog)
        else $error("write started on program memory");
    chk_prog_bounded: assert property (
        ee_prog |-> prog_cnt_q < prog_limit)
        else $error("programming passed its limit");
    chk_verify_ends: assert property (
        (ee_prog && ee_verify_ok) |=> !ee_prog && !wr_q)
        else $error("write did not end on self-check");
    chk_stall_write: assert property (
        $rose(wr_q) |-> cpu_stall && ee_prog)
        else $error("core not stalled during write");
    chk_por_block: assert property (
        (por_busy && idle) |=> !ee_prog)
        else $error("write started in power-on delay");
    chk_unlock_gate: assert property (
        $rose(ee_prog) |-> $past(unlock_q) == UNL_ARMED && $past(pwdata[CTL_ALLOW]))
        else $error("write started while locked");
    chk_timeout_error: assert property (
        tmo_ev |=> err_q && flag_q[FLG_ERR] && flag_q[FLG_DONE] && !cpu_stall)
        else $error("timeout did not flag error");
    chk_done_flag: assert property (
        ok_ev |=> flag_q[FLG_DONE] && !wr_q)
        else $error("done flag not set");

    cov_prog_read: cover property (prog_rd ##2 !cpu_squash);
    cov_write_ok: cover property ($rose(ee_prog) ##[1:1000] ok_ev);
    cov_write_timeout: cover property (tmo_ev);
    cov_irq_raise: cover property ($rose(irq));
endmodule

/* psa_array_model.sv */
// Behavioural program memory and EEPROM arrays behind the controller
`timescale 1ns/100ps
module psa_array_model
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Program memory side
    input  wire logic [10:0] prog_addr,
    input  wire logic        prog_rd,
    output logic      [15:0] prog_rdata,
    // EEPROM side
    input  wire logic [7:0]  ee_addr,
    input  wire logic [7:0]  ee_wdata,
    input  wire logic        ee_rd,
    input  wire logic        ee_prog,
    output logic      [7:0]  ee_rdata,
    output logic             ee_verify_ok,
    // Self-check delay in cycles, zero never succeeds
    input  wire logic [7:0]  verify_cyc
);
    logic [7:0] mem_q [256];
    logic [7:0] cnt_q;
    // ==========================================================
    // Array data valid one cycle after a strobe, toggling otherwise
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prog_rdata <= 16'h0000;
            ee_rdata <= 8'h00;
            cnt_q <= 8'h00;
            ee_verify_ok <= 1'b0;
        end
        else
        begin
            prog_rdata <= prog_rd ? {5'h15, prog_addr} : ~prog_rdata;
            ee_rdata <= ee_rd ? mem_q[ee_addr] : ~ee_rdata;
            cnt_q <= (ee_prog && !ee_verify_ok) ? cnt_q + 8'h01 : 8'h00;
            // Self-check passes after a delay set by verify_cyc
            ee_verify_ok <= ee_prog && verify_cyc != 8'h00 && cnt_q == verify_cyc - 8'h01;
            if (ee_prog && verify_cyc != 8'h00 && cnt_q == verify_cyc - 8'h01)
                mem_q[ee_addr] <= ee_wdata;
        end
    end
endmodule

/* tb_program_store_access_ctrl.sv */
// Self-checking testbench for the program store access controller
`timescale 1ns/100ps
module tb_program_store_access_ctrl;
    import psa_pkg::*;
    // ==========================================================
    // Signals
    localparam int MAX_CYC = 64;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        cpu_stall;
    logic        cpu_squash;
    logic        wdt_lvr_reset = 1'b0;
    logic [10:0] prog_addr;
    logic        prog_rd;
    logic [15:0] prog_rdata;
    logic [7:0]  ee_addr;
    logic [7:0]  ee_wdata;
    logic        ee_rd;
    logic [7:0]  ee_rdata;
    logic        ee_prog;
    logic        ee_verify_ok;
    logic [7:0]  verify_cyc = 8'h0a;
    logic [31:0] rd;
    logic        err_q;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          n;
    int          i;

    always #5 clk_sys = ~clk_sys;

    psa_program_store_access_ctrl #(.PWR_ON_CYC_P(20), .PROG_MAX_CYC_P(MAX_CYC))
        psa_program_store_access_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .cpu_stall(cpu_stall),
        .cpu_squash(cpu_squash), .wdt_lvr_reset(wdt_lvr_reset), .prog_addr(prog_addr),
        .prog_rd(prog_rd), .prog_rdata(prog_rdata), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
        .ee_rd(ee_rd), .ee_rdata(ee_rdata), .ee_prog(ee_prog), .ee_verify_ok(ee_verify_ok));

    psa_array_model psa_array_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata), .ee_addr(ee_addr),
        .ee_wdata(ee_wdata), .ee_rd(ee_rd), .ee_prog(ee_prog), .ee_rdata(ee_rdata),
        .ee_verify_ok(ee_verify_ok), .verify_cyc(verify_cyc));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("Mismatches %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic ee_write(input logic [7:0] ctl);
        apb(1'b1, OFS_UNLOCK, 32'h55);
        apb(1'b1, OFS_UNLOCK, 32'haa);
        apb(1'b1, OFS_CONTROL, {24'h0, ctl});
    endtask

    // Counts stall cycles from the start edge, giving up after lim samples
    task automatic stall_len(input int lim);
        int k;
        n = 0;
        for (k = 0; k < lim; k++)
        begin
            #1;
            if (cpu_stall === 1'b1)
                n++;
            else if (n > 0)
                break;
            @(posedge clk_sys);
        end
    endtask

    // ==========================================================
    // Sequence
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(OFS_CONTROL, 32'h0);
        ee_write(8'h36);
        stall_len(12);
        chk(n, 0);
        rdc(OFS_FLAGS, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk(err_q, 1'b1);
        apb(1'b1, OFS_ADDR_LOW, 32'ha3);
        apb(1'b1, OFS_ADDR_HIGH, 32'h5);
        apb(1'b1, OFS_CONTROL, 32'h80);
        apb(1'b1, OFS_CONTROL, 32'h81);
        #1;
        for (i = 0; i < 4 && prog_rd !== 1'b1; i++)
        begin
            @(posedge clk_sys);
            #1;
        end
        chk(prog_rd, 1'b1);
        chk(prog_addr, 11'h5a3);
        @(posedge clk_sys);
        #1;
        chk(cpu_squash, 1'b1);
        repeat (2) @(posedge clk_sys);
        rdc(OFS_DATA_LOW, 32'ha3);
        rdc(OFS_DATA_HIGH, 32'had);
        rdc(OFS_CONTROL, 32'h80);
        rdc(OFS_ADDR_LOW, 32'ha3);
        rdc(OFS_DATA_HIGH, 32'had);
        ee_write(8'h86);
        stall_len(12);
        chk(n, 0);
        rdc(OFS_CONTROL, 32'h84);
        apb(1'b1, OFS_CONTROL, 32'h06);
        stall_len(12);
        chk(n, 0);
        apb(1'b1, OFS_UNLOCK, 32'haa);
        apb(1'b1, OFS_UNLOCK, 32'h55);
        apb(1'b1, OFS_CONTROL, 32'h06);
        stall_len(12);
        chk(n, 0);
        ee_write(8'h02);
        stall_len(12);
        chk(n, 0);
        apb(1'b1, OFS_ADDR_LOW, 32'h3c);
        apb(1'b1, OFS_DATA_LOW, 32'h96);
        apb(1'b1, OFS_MASK, 32'h3);
        ee_write(8'h36);
        stall_len(200);
        chk(n >= 10 && n <= 12, 1'b1);
        rdc(OFS_FLAGS, 32'h1);
        chk(irq, 1'b1);
        rdc(OFS_CONTROL, 32'h34);
        apb(1'b1, OFS_FLAGS, 32'h1);
        rdc(OFS_FLAGS, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, OFS_CONTROL, 32'h01);
        repeat (4) @(posedge clk_sys);
        rdc(OFS_DATA_LOW, 32'h96);
        rdc(OFS_DATA_HIGH, 32'h0);
        verify_cyc <= 8'h00;
        for (i = 0; i < 4; i++)
        begin
            ee_write({2'b00, i[1:0], 4'h6});
            stall_len(200);
            chk(n, MAX_CYC >> (3 - i));
            rdc(OFS_FLAGS, 32'h3);
            chk(irq, 1'b1);
            apb(1'b1, OFS_FLAGS, 32'h3);
        end
        apb(1'b1, OFS_MASK, 32'h0);
        ee_write(8'h36);
        repeat (3) @(posedge clk_sys);
        wdt_lvr_reset <= 1'b1;
        @(posedge clk_sys);
        wdt_lvr_reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk(cpu_stall, 1'b0);
        rdc(OFS_FLAGS, 32'h2);
        chk(irq, 1'b0);
        rdc(OFS_CONTROL, 32'h3c);
        summarize();
    end
endmodule
